// >>> hdl/faa_defines.svh
// Constants of the float absolute / add-immediate datapath.
// Assumes the includer also imports faa_pkg for the types.
// What this block does
// - Operand fields pick one of eight registers
// - Absolute value clears only the sign bit
// - Decode add-immediate from its two-word encoding
// - Immediate is upper half, low half zeros
// - Add source and immediate, write destination
// - Result equals source plus immediate:16'h0000
// - Underflow sets latched underflow, other flags kept
// - Overflow sets latched overflow flag
// - Add result lands after the following instruction
`ifndef FAA_DEFINES_SVH
`define FAA_DEFINES_SVH

// Working register count
`define FAA_NUM_REGS 8
// Add-immediate fixed prefix, low word bits 15:6
`define FAA_ADDI_PREFIX 10'h3a2
// Absolute value low word, whole word matched
`define FAA_ABS_LSW 16'he400
// Bus offsets: working registers sit at 8'h00..8'h07
`define FAA_OFS_REG0 8'h00
`define FAA_OFS_STATUS 8'h08
`define FAA_OFS_INT_STAT 8'h09
`define FAA_OFS_INT_MASK 8'h0a
// Status word bit positions
`define FAA_SF_LVF 0
`define FAA_SF_LUF 1
`define FAA_SF_NF 2
`define FAA_SF_ZF 3
`define FAA_SF_NI 4
`define FAA_SF_ZI 5
`define FAA_SF_TF 6
// Interrupt event bit positions
`define FAA_EV_OVF 0
`define FAA_EV_UNF 1
`define FAA_EV_ADD_DONE 2
`define FAA_EV_ILLEGAL 3
// Reset values
`define FAA_STATUS_RST 7'h00
`define FAA_INT_MASK_RST 4'h0

`endif

// >>> hdl/faa_pkg.sv
// Types of the float absolute / add-immediate datapath.
// Assumes one clock domain and a host that issues whole instructions.
package faa_pkg;

  // One issued instruction, both words at once
  typedef struct packed {
    logic valid;
    logic [15:0] lsw;
    logic [15:0] msw;
  } faa_instr_t;

  // Register port request, one cycle per strobe
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } faa_bus_req_t;

  // Pending add in its second pipeline cycle
  typedef struct packed {
    logic busy;
    logic [2:0] dst;
    logic [31:0] opa;
    logic [31:0] opb;
  } faa_add_stage_t;

  // Whole block state
  typedef struct packed {
    logic [7:0][31:0] regs;
    logic [6:0] status;
    faa_add_stage_t add;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic [31:0] rdata;
  } faa_state_t;

endpackage

// >>> hdl/faa_datapath.sv
// Float absolute value and add-immediate datapath with eight working
// registers, status flags, register port and one interrupt line.
// Assumes instructions and port strobes come from logic on clock_in.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "faa_defines.svh"

module faa_datapath
  import faa_pkg::*;
#(
  parameter int NUM_REGS = `FAA_NUM_REGS
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire faa_instr_t instr_in,
  input wire faa_bus_req_t bus_in,
  output logic [31:0] rd_data_out,
  output logic [6:0] status_out,
  output logic add_busy_out,
  output logic irq_out
);

  // Register fields are three bits wide, so exactly eight registers
  initial begin
    if (NUM_REGS != `FAA_NUM_REGS) begin
      $error("NUM_REGS must be 8");
    end
  end

  // Adder result bundle
  typedef struct packed {
    logic [31:0] value;
    logic ovf;
    logic unf;
  } faa_sum_t;

  // Leading zero count of a 27-bit mantissa field
  function automatic logic [4:0] lzc27(input logic [26:0] v);
    logic [4:0] n;
    logic found;
    n = 5'd0;
    found = 1'b0;
    for (int i = 26; i >= 0; i--) begin
      if (!found && v[i]) begin
        found = 1'b1;
      end else if (!found) begin
        n = n + 5'd1;
      end
    end
    return n;
  endfunction

  // Right shift that folds lost bits into bit zero
  function automatic logic [26:0] shr_sticky(input logic [26:0] v, input logic [7:0] sh);
    logic [26:0] r;
    logic lost;
    r = 27'h0000000;
    lost = 1'b0;
    if (sh >= 8'd27) begin
      lost = |v;
    end else begin
      r = v >> sh;
      lost = |(v & ~(27'h7ffffff << sh));
    end
    return {r[26:1], r[0] | lost};
  endfunction

  // Single precision add, round to nearest even; denormals read as
  // zero and tiny results flush to zero, which keeps the adder small
  function automatic faa_sum_t fadd(input logic [31:0] a, input logic [31:0] b);
    faa_sum_t res;
    logic [31:0] big;
    logic [31:0] sml;
    logic [26:0] mbig;
    logic [26:0] msml;
    logic [27:0] sum;
    logic [26:0] norm;
    logic [4:0] lz;
    logic signed [9:0] exp;
    logic [24:0] mant;
    logic up;
    res = '0;
    big = a;
    sml = b;
    sum = 28'h0000000;
    norm = 27'h0000000;
    lz = 5'd0;
    exp = 10'sd0;
    mant = 25'h0000000;
    up = 1'b0;
    // Order by magnitude so the subtraction never goes negative
    if (b[30:0] > a[30:0]) begin
      big = b;
      sml = a;
    end
    mbig = {(big[30:23] != 8'h00), big[22:0], 3'b000};
    msml = {(sml[30:23] != 8'h00), sml[22:0], 3'b000};
    if (big[30:23] == 8'hff) begin
      // Infinity or not-a-number passes through unchanged
      res.value = big;
    end else if (big[30:23] == 8'h00) begin
      // Both operands zero or denormal
      res.value = 32'h00000000;
    end else begin
      if (sml[30:23] == 8'h00) begin
        msml = 27'h0000000;
      end
      msml = shr_sticky(msml, big[30:23] - sml[30:23]);
      if (big[31] == sml[31]) begin
        sum = {1'b0, mbig} + {1'b0, msml};
      end else begin
        sum = {1'b0, mbig} - {1'b0, msml};
      end
      exp = signed'({2'b00, big[30:23]});
      if (sum == 28'h0000000) begin
        // Exact cancellation gives positive zero
        res.value = 32'h00000000;
      end else begin
        // Normalise: carry out shifts right, otherwise left
        if (sum[27]) begin
          norm = {sum[27:2], sum[1] | sum[0]};
          exp = exp + 10'sd1;
        end else begin
          lz = lzc27(sum[26:0]);
          norm = sum[26:0] << lz;
          exp = exp - signed'({5'b00000, lz});
        end
        up = norm[2] & ((|norm[1:0]) | norm[3]);
        mant = {1'b0, norm[26:3]} + {24'h000000, up};
        if (mant[24]) begin
          mant = mant >> 1;
          exp = exp + 10'sd1;
        end
        if (exp >= 10'sd255) begin
          // Too large: signed infinity
          res.value = {big[31], 8'hff, 23'h000000};
          res.ovf = 1'b1;
        end else if (exp <= 10'sd0) begin
          // Too small: signed zero
          res.value = {big[31], 31'h00000000};
          res.unf = 1'b1;
        end else begin
          res.value = {big[31], exp[7:0], mant[22:0]};
        end
      end
    end
    return res;
  endfunction

  faa_state_t state_q;
  faa_state_t state_d;
  faa_sum_t sum_w; // Adder output for the pending add
  logic is_add; // Issued word is an add-immediate
  logic is_abs; // Issued word is an absolute value
  logic [2:0] src_idx; // Source register field
  logic [2:0] dst_idx; // Destination register field
  logic [31:0] abs_val; // Absolute value result
  logic [3:0] events; // One-cycle event pulses

  // Decode of the issued instruction
  always_comb begin
    is_add = instr_in.valid && instr_in.lsw[15:6] == `FAA_ADDI_PREFIX;
    is_abs = instr_in.valid && instr_in.lsw == `FAA_ABS_LSW && instr_in.msw[15:6] == 10'h000;
    src_idx = instr_in.msw[5:3];
    dst_idx = instr_in.msw[2:0];
    abs_val = {1'b0, state_q.regs[src_idx][30:0]};
  end

  // Adder works on the operands latched at issue
  always_comb begin
    sum_w = fadd(state_q.add.opa, state_q.add.opb);
  end

  // Next state: bus, then instruction, then pending add completion
  always_comb begin
    state_d = state_q;
    events = 4'h0;
    state_d.rdata = 32'h00000000;
    // Register port writes, lowest priority for working registers
    if (bus_in.wr) begin
      if (bus_in.addr < `FAA_OFS_STATUS) begin
        state_d.regs[bus_in.addr[2:0]] = bus_in.wdata;
      end else if (bus_in.addr == `FAA_OFS_STATUS) begin
        state_d.status = bus_in.wdata[6:0];
      end else if (bus_in.addr == `FAA_OFS_INT_MASK) begin
        state_d.int_mask = bus_in.wdata[3:0];
      end
    end
    // Register port reads, data stand in the next cycle only
    if (bus_in.rd) begin
      if (bus_in.addr < `FAA_OFS_STATUS) begin
        state_d.rdata = state_q.regs[bus_in.addr[2:0]];
      end else if (bus_in.addr == `FAA_OFS_STATUS) begin
        state_d.rdata = {25'h0000000, state_q.status};
      end else if (bus_in.addr == `FAA_OFS_INT_STAT) begin
        state_d.rdata = {28'h0000000, state_q.int_stat};
      end else if (bus_in.addr == `FAA_OFS_INT_MASK) begin
        state_d.rdata = {28'h0000000, state_q.int_mask};
      end
    end
    // Second stage: pipeline slot drains every cycle
    state_d.add.busy = 1'b0;
    // Issue stage
    if (is_add) begin
      // Operands latched now, result written one cycle later
      state_d.add.busy = 1'b1;
      state_d.add.dst = dst_idx;
      state_d.add.opa = state_q.regs[src_idx];
      state_d.add.opb = {instr_in.lsw[5:0], instr_in.msw[15:6], 16'h0000};
    end else if (is_abs) begin
      // Written at this edge, only sign and zero flags move
      state_d.regs[dst_idx] = abs_val;
      state_d.status[`FAA_SF_NF] = 1'b0;
      state_d.status[`FAA_SF_ZF] = (abs_val[30:23] == 8'h00);
    end else if (instr_in.valid) begin
      events[`FAA_EV_ILLEGAL] = 1'b1;
    end
    // Completion; the host keeps the slot clear of this register,
    // so a clash with the slot instruction cannot occur in order
    if (state_q.add.busy) begin
      state_d.regs[state_q.add.dst] = sum_w.value;
      events[`FAA_EV_ADD_DONE] = 1'b1;
      if (sum_w.unf) begin
        state_d.status[`FAA_SF_LUF] = 1'b1;
        events[`FAA_EV_UNF] = 1'b1;
      end
      if (sum_w.ovf) begin
        state_d.status[`FAA_SF_LVF] = 1'b1;
        events[`FAA_EV_OVF] = 1'b1;
      end
    end
    // Sticky events: a one clears, a new event in the same cycle wins
    if (bus_in.wr && bus_in.addr == `FAA_OFS_INT_STAT) begin
      state_d.int_stat = state_q.int_stat & ~bus_in.wdata[3:0];
    end
    state_d.int_stat = state_d.int_stat | events;
  end

  // State register, synchronous reset
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_q <= '0;
      state_q.status <= `FAA_STATUS_RST;
      state_q.int_mask <= `FAA_INT_MASK_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state register
  always_comb begin
    rd_data_out = state_q.rdata;
    status_out = state_q.status;
    add_busy_out = state_q.add.busy;
    irq_out = |(state_q.int_stat & state_q.int_mask);
  end

endmodule // faa_datapath

// >>> verif/faa_assertions.sv
// Port checker for the float absolute / add-immediate datapath.
// Assumes it is bound onto faa_datapath: one clock, synchronous reset.
`timescale 1ns/100ps
`include "faa_defines.svh"
module faa_checker
  import faa_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire faa_instr_t instr_in,
  input wire faa_bus_req_t bus_in,
  input wire logic [31:0] rd_data_out,
  input wire logic [6:0] status_out,
  input wire logic add_busy_out,
  input wire logic irq_out
);
  // Decoded request kinds
  logic is_add, is_abs, st_wr;
  assign is_add = instr_in.valid && instr_in.lsw[15:6] == `FAA_ADDI_PREFIX;
  assign is_abs = instr_in.valid && instr_in.lsw == `FAA_ABS_LSW && instr_in.msw[15:6] == 10'h000;
  // Status writes may legally move any flag
  assign st_wr = bus_in.wr && bus_in.addr == `FAA_OFS_STATUS;
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  chk_busy_after_add: assert property (is_add |=> add_busy_out)
    else $error("busy missing after add");
  chk_busy_one: assert property (add_busy_out && !is_add |=> !add_busy_out)
    else $error("busy held too long");
  chk_abs_neg: assert property (is_abs |=> !status_out[`FAA_SF_NF])
    else $error("abs left negative set");
  chk_add_keeps: assert property (add_busy_out && !is_abs && !st_wr |=> $stable(status_out[6:2]))
    else $error("add moved other flags");
  chk_luf_cause: assert property ($rose(status_out[1]) |-> $past(add_busy_out || st_wr))
    else $error("underflow set without add");
  chk_lvf_cause: assert property ($rose(status_out[0]) |-> $past(add_busy_out || st_wr))
    else $error("overflow set without add");
  // Mid-run reset may drop the latched flags too
  chk_flags_sticky: assert property (|($past(status_out[1:0]) & ~status_out[1:0])
    |-> $past(st_wr || srst_in))
    else $error("latched flag dropped");
  chk_odd_quiet: assert property (instr_in.valid && !is_add && !is_abs && !add_busy_out
    && !bus_in.wr |=> $stable(status_out))
    else $error("unknown instruction moved flags");
endmodule // faa_checker

bind faa_datapath faa_checker u_chk (.clock_in, .srst_in, .instr_in, .bus_in,
  .rd_data_out, .status_out, .add_busy_out, .irq_out);

// >>> verif/faa_host_model.sv
// Host pipeline model issuing whole instructions to the datapath.
// Assumes callers start each task just after a rising edge.
`timescale 1ns/100ps
`include "faa_defines.svh"
module faa_host_model
  import faa_pkg::*;
(
  input wire logic clock_in,
  output faa_instr_t instr_out
);
  initial instr_out = '0;
  // One instruction, then an idle slot with scrambled words
  task automatic issue(input logic [15:0] lsw, input logic [15:0] msw);
    instr_out <= '{1'b1, lsw, msw};
    @(posedge clock_in);
    instr_out <= '{1'b0, ~lsw, ~msw};
    @(posedge clock_in);
  endtask
  // Add-immediate encoding, immediate split over both words
  task automatic add(input logic [2:0] s, input logic [2:0] d, input logic [15:0] imm);
    issue({`FAA_ADDI_PREFIX, imm[15:10]}, {imm[9:0], s, d});
  endtask
  // Absolute value encoding
  task automatic abs(input logic [2:0] s, input logic [2:0] d);
    issue(`FAA_ABS_LSW, {10'h000, s, d});
  endtask
endmodule // faa_host_model

// >>> verif/fpu_abs_and_add_immediate_bench.sv
// Self-checking bench for the float absolute / add-immediate datapath.
// Assumes the host model drives instructions, the bench the register port.
`timescale 1ns/100ps
`include "faa_defines.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module fpu_abs_and_add_immediate_bench
  import faa_pkg::*;
;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  faa_instr_t instr;
  faa_bus_req_t bus = '0;
  logic [31:0] rd_data;
  logic [6:0] status;
  logic busy, irq;
  int n_fail = 0, comparisons = 0, cyc = 0;
  // Operands: 1.0, 2.0, near max, tiny normal, negative zero
  logic [31:0] init_v [8] = '{32'h11111111, 32'h3f800000, 32'h40000000, 32'h33333333,
    32'h7f7f0000, 32'h00c00000, 32'h80000000, 32'h77777777};
  initial forever #50 clock_in = ~clock_in;
  faa_datapath DUT (.clock_in, .srst_in, .instr_in(instr), .bus_in(bus),
    .rd_data_out(rd_data), .status_out(status), .add_busy_out(busy), .irq_out(irq));
  faa_host_model host (.clock_in, .instr_out(instr));
  // Write, with a spare edge so strobes never re-rise in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clock_in);
    bus <= '0;
    @(posedge clock_in);
  endtask
  // Read data stand only in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock_in);
    bus <= '0;
    @(negedge clock_in);
    `CHK("rd_data", e, rd_data)
    @(posedge clock_in);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, far above the run length
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    rd(`FAA_OFS_STATUS, 32'h0);
    for (int i = 0; i < 8; i++) wr(8'(i), init_v[i]);
    for (int i = 0; i < 8; i++) rd(8'(i), init_v[i]);
    host.add(3'd1, 3'd0, 16'h4000);
    rd(8'h00, 32'h40400000);
    host.add(3'd2, 3'd2, 16'hc020);
    rd(8'h02, 32'hbf000000);
    `CHK("status", 7'h00, status)
    host.abs(3'd2, 3'd3);
    rd(8'h03, 32'h3f000000);
    host.abs(3'd6, 3'd7);
    rd(8'h07, 32'h00000000);
    `CHK("status", 7'h08, status)
    host.add(3'd4, 3'd4, 16'h7f7f);
    rd(8'h04, 32'h7f800000);
    `CHK("status", 7'h09, status)
    host.add(3'd5, 3'd5, 16'h8080);
    rd(8'h05, 32'h0);
    rd(`FAA_OFS_STATUS, 32'h0b);
    rd(`FAA_OFS_INT_STAT, 32'h7);
    `CHK("irq", 1'b0, irq)
    wr(`FAA_OFS_INT_MASK, 32'h2);
    `CHK("irq", 1'b1, irq)
    wr(`FAA_OFS_INT_STAT, 32'h2);
    `CHK("irq", 1'b0, irq)
    host.issue(16'h0000, 16'h0000);
    rd(`FAA_OFS_INT_STAT, 32'h0d);
    wr(`FAA_OFS_INT_STAT, 32'hf);
    wr(`FAA_OFS_STATUS, 32'h0);
    rd(`FAA_OFS_STATUS, 32'h0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h0);
    rd(`FAA_OFS_INT_STAT, 32'h0);
    results();
  end
endmodule // fpu_abs_and_add_immediate_bench
